// File: common/orm_pkg.sv
// Shared constants and types for the OR and move instruction executer
package orm_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 12;
  localparam int WORD_W    = 16;
  localparam int BANK_W    = 4;
  localparam int PTR_COUNT = 3;
  localparam int SEL_W     = 2;

  // ------------------------------------------------------------------
  // Instruction field positions
  // ------------------------------------------------------------------
  localparam int OPC8_LSB    = 8;
  localparam int OPC7_LSB    = 9;
  localparam int OPC6_LSB    = 10;
  localparam int OPC10_LSB   = 6;
  localparam int OPC4_LSB    = 12;
  localparam int DEST_BIT    = 9;
  localparam int ACCESS_BIT  = 8;
  localparam int PTR_SEL_LSB = 4;

  // ------------------------------------------------------------------
  // Opcode patterns
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_OR_LIT    = 8'h09;
  localparam logic [7:0] OPC_LOAD_LIT  = 8'h0e;
  localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
  localparam logic [5:0] OPC_OR_FILE   = 6'h04;
  localparam logic [5:0] OPC_COPY_FILE = 6'h14;
  localparam logic [6:0] OPC_STORE_ACC = 7'h37;
  localparam logic [9:0] OPC_LOAD_PTR  = 10'h3b8;
  localparam logic [3:0] OPC_F2F_FIRST = 4'hc;

  // ------------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------------
  localparam logic [7:0]        ACCESS_SPLIT = 8'h5f;
  localparam logic [BANK_W-1:0] ACCESS_LOW   = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH  = 4'hf;
  localparam logic [ADDR_W-1:0] ACC_ADDR     = 12'hfe0;
  localparam int                IDX_PTR      = 2;
  localparam logic [SEL_W-1:0]  PTR_LAST     = 2'h2;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE
  } orm_phase_type;

  typedef enum logic [3:0] {
    OP_IDLE, OP_OR_LIT, OP_OR_FILE, OP_COPY_FILE, OP_LOAD_LIT,
    OP_LOAD_BANK, OP_STORE_ACC, OP_PTR_HIGH, OP_PTR_LOW,
    OP_F2F_SRC, OP_F2F_DST
  } orm_op_type;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } orm_write_type;

  typedef logic [PTR_COUNT-1:0][ADDR_W-1:0] orm_ptr_type;

  typedef struct packed {
    orm_phase_type     phase;
    orm_op_type        op;
    logic              pendPtr;
    logic              pendMove;
    logic [WORD_W-1:0] instr;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] bank;
    orm_ptr_type       ptr;
    logic [SEL_W-1:0]  ptrSel;
    logic              neg;
    logic              zero;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] result;
    logic [ADDR_W-1:0] rdAddr;
    orm_write_type     wr;
  } orm_state_type;

endpackage : orm_pkg

// File: design/orm_addr_gen.sv
// Data address formation for single-word file register instructions
`timescale 1ns/10ps
module orm_addr_gen
  import orm_pkg::*;
(
  input  wire logic [DATA_W-1:0] fileAddr,
  input  wire logic              accessBit,
  input  wire logic [BANK_W-1:0] bankNibble,
  input  wire logic              extEnable,
  input  wire logic [ADDR_W-1:0] ptrBase,
  output      logic [ADDR_W-1:0] dataAddr
);

  // ------------------------------------------------------------------
  // Bank, access and indexed selection
  // ------------------------------------------------------------------
  always_comb begin
    if (accessBit) begin
      dataAddr = {bankNibble, fileAddr};
    end else if (extEnable && fileAddr <= ACCESS_SPLIT) begin
      // Indexed offset wraps at the top of the data space
      dataAddr = ptrBase + {{(ADDR_W-DATA_W){1'b0}}, fileAddr};
    end else if (fileAddr <= ACCESS_SPLIT) begin
      dataAddr = {ACCESS_LOW, fileAddr};
    end else begin
      dataAddr = {ACCESS_HIGH, fileAddr};
    end
  end

endmodule : orm_addr_gen

// File: design/orm_exec.sv
// Decode and execute of the OR, literal and move instruction group
`timescale 1ns/10ps
module orm_exec
  import orm_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [WORD_W-1:0]   instrWord,
  input  wire logic                extEnable,
  input  wire logic [DATA_W-1:0]   memRdData,
  output      logic                fetchStrobe,
  output      logic [ADDR_W-1:0]   memRdAddr,
  output      orm_write_type       memWrite,
  output      logic [DATA_W-1:0]   accumulator,
  output      logic [DATA_W-1:0]   bankSelect,
  output      orm_ptr_type         pointers,
  output      logic                negFlag,
  output      logic                zeroFlag,
  output      orm_phase_type       phase
);

  // ------------------------------------------------------------------
  // State and helpers
  // ------------------------------------------------------------------
  orm_state_type     state_reg;
  orm_state_type     state_next;
  logic [ADDR_W-1:0] fileAddr;
  logic              resNeg;
  logic              resZero;
  logic              fileOp;
  logic              toFile;
  logic [DATA_W-1:0] literal;

  assign literal = state_reg.instr[DATA_W-1:0];
  assign toFile  = state_reg.instr[DEST_BIT];
  assign fileOp  = (state_reg.op == OP_OR_FILE) ||
                   (state_reg.op == OP_COPY_FILE) ||
                   (state_reg.op == OP_STORE_ACC);

  orm_addr_gen u_addr (
    .fileAddr   (instrWord[DATA_W-1:0]),
    .accessBit  (instrWord[ACCESS_BIT]),
    .bankNibble (state_reg.bank[BANK_W-1:0]),
    .extEnable  (extEnable),
    .ptrBase    (state_reg.ptr[IDX_PTR]),
    .dataAddr   (fileAddr)
  );

  orm_flag_calc u_flags (
    .value   (state_reg.result),
    .negOut  (resNeg),
    .zeroOut (resZero)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg.phase)
      PH_DECODE: begin
        state_next.phase = PH_READ;
        state_next.instr = instrWord;
        state_next.rdAddr = fileAddr;
        state_next.op = OP_IDLE;
        state_next.pendPtr = 1'b0;
        state_next.pendMove = 1'b0;
        if (state_reg.pendMove) begin
          state_next.op = OP_F2F_DST;
        end else if (state_reg.pendPtr) begin
          state_next.op = OP_PTR_LOW;
        end else if (instrWord[WORD_W-1:OPC8_LSB] == OPC_OR_LIT) begin
          state_next.op = OP_OR_LIT;
        end else if (instrWord[WORD_W-1:OPC8_LSB] == OPC_LOAD_LIT) begin
          state_next.op = OP_LOAD_LIT;
        end else if (instrWord[WORD_W-1:OPC8_LSB] == OPC_LOAD_BANK) begin
          state_next.op = OP_LOAD_BANK;
        end else if (instrWord[WORD_W-1:OPC6_LSB] == OPC_OR_FILE) begin
          state_next.op = OP_OR_FILE;
        end else if (instrWord[WORD_W-1:OPC6_LSB] == OPC_COPY_FILE) begin
          state_next.op = OP_COPY_FILE;
        end else if (instrWord[WORD_W-1:OPC7_LSB] == OPC_STORE_ACC) begin
          state_next.op = OP_STORE_ACC;
        end else if (instrWord[WORD_W-1:OPC10_LSB] == OPC_LOAD_PTR) begin
          state_next.op = OP_PTR_HIGH;
        end else if (instrWord[WORD_W-1:OPC4_LSB] == OPC_F2F_FIRST) begin
          state_next.op = OP_F2F_SRC;
          // Full 12-bit address, no banking applied
          state_next.rdAddr = instrWord[ADDR_W-1:0];
        end
      end
      PH_READ: begin
        state_next.phase = PH_PROCESS;
        unique case (state_reg.op)
          OP_OR_FILE, OP_COPY_FILE, OP_F2F_SRC: begin
            // The accumulator has no memory cell behind its address
            if (state_reg.rdAddr == ACC_ADDR) begin
              state_next.opnd = state_reg.acc;
            end else begin
              state_next.opnd = memRdData;
            end
          end
          OP_STORE_ACC: begin
            state_next.opnd = state_reg.acc;
          end
          OP_F2F_DST: begin
            state_next.opnd = state_reg.opnd;
          end
          default: begin
            state_next.opnd = literal;
          end
        endcase
      end
      PH_PROCESS: begin
        state_next.phase = PH_WRITE;
        state_next.wr.data = state_reg.opnd;
        state_next.wr.addr = state_reg.rdAddr;
        state_next.wr.en = 1'b0;
        if (state_reg.op == OP_OR_LIT || state_reg.op == OP_OR_FILE) begin
          state_next.result = state_reg.acc | state_reg.opnd;
        end else begin
          state_next.result = state_reg.opnd;
        end
        unique case (state_reg.op)
          OP_OR_FILE: begin
            state_next.wr.data = state_reg.acc | state_reg.opnd;
            state_next.wr.en = toFile;
          end
          OP_COPY_FILE: begin
            state_next.wr.en = toFile;
          end
          OP_STORE_ACC: begin
            state_next.wr.en = 1'b1;
          end
          OP_F2F_DST: begin
            // Program counter and stack top targets are left to software
            state_next.wr.addr = state_reg.instr[ADDR_W-1:0];
            state_next.wr.en = (state_reg.instr[ADDR_W-1:0] != ACC_ADDR);
          end
          default: begin
            state_next.wr.en = 1'b0;
          end
        endcase
      end
      PH_WRITE: begin
        state_next.phase = PH_DECODE;
        state_next.wr.en = 1'b0;
        state_next.op = OP_IDLE;
        unique case (state_reg.op)
          OP_OR_LIT: begin
            state_next.acc = state_reg.result;
            state_next.neg = resNeg;
            state_next.zero = resZero;
          end
          OP_OR_FILE, OP_COPY_FILE: begin
            if (!toFile) begin
              state_next.acc = state_reg.result;
            end
            state_next.neg = resNeg;
            state_next.zero = resZero;
          end
          OP_LOAD_LIT: begin
            state_next.acc = state_reg.result;
          end
          OP_LOAD_BANK: begin
            state_next.bank = {{(DATA_W-BANK_W){1'b0}},
                               state_reg.result[BANK_W-1:0]};
          end
          OP_PTR_HIGH: begin
            state_next.pendPtr = 1'b1;
            state_next.ptrSel =
              state_reg.instr[PTR_SEL_LSB+SEL_W-1:PTR_SEL_LSB];
            // A selector of three names no pointer and is dropped
            if (state_next.ptrSel <= PTR_LAST) begin
              state_next.ptr[state_next.ptrSel][ADDR_W-1:DATA_W] =
                state_reg.instr[ADDR_W-DATA_W-1:0];
            end
          end
          OP_PTR_LOW: begin
            if (state_reg.ptrSel <= PTR_LAST) begin
              state_next.ptr[state_reg.ptrSel][DATA_W-1:0] =
                state_reg.result;
            end
          end
          OP_F2F_SRC: begin
            state_next.pendMove = 1'b1;
          end
          OP_F2F_DST: begin
            if (state_reg.instr[ADDR_W-1:0] == ACC_ADDR) begin
              state_next.acc = state_reg.result;
            end
          end
          default: begin
            state_next.acc = state_reg.acc;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign fetchStrobe = (state_reg.phase == PH_DECODE);
  assign memRdAddr   = state_reg.rdAddr;
  assign memWrite    = state_reg.wr;
  assign accumulator = state_reg.acc;
  assign bankSelect  = state_reg.bank;
  assign pointers    = state_reg.ptr;
  assign negFlag     = state_reg.neg;
  assign zeroFlag    = state_reg.zero;
  assign phase       = state_reg.phase;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic freshDecode;
  assign freshDecode = fetchStrobe && !state_reg.pendPtr &&
                       !state_reg.pendMove;

  a_phase_order: assert property (@(posedge clock) disable iff (rst)
    phase == PH_DECODE |=> phase == PH_READ ##1 phase == PH_PROCESS
      ##1 phase == PH_WRITE ##1 phase == PH_DECODE)
    else $error("quarter phases out of order");

  a_or_literal: assert property (@(posedge clock) disable iff (rst)
    freshDecode && instrWord[WORD_W-1:OPC8_LSB] == OPC_OR_LIT |->
      ##4 accumulator == ($past(accumulator, 4) |
                          $past(instrWord[DATA_W-1:0], 4)))
    else $error("or literal result wrong");

  a_flag_values: assert property (@(posedge clock) disable iff (rst)
    phase == PH_WRITE && (state_reg.op == OP_OR_LIT ||
      (state_reg.op == OP_COPY_FILE && !toFile)) |=>
      zeroFlag == (accumulator == '0) && negFlag == accumulator[DATA_W-1])
    else $error("negative or zero flag wrong");

  a_literal_keep: assert property (@(posedge clock) disable iff (rst)
    freshDecode && instrWord[WORD_W-1:OPC8_LSB] == OPC_LOAD_LIT |->
      ##4 accumulator == $past(instrWord[DATA_W-1:0], 4) &&
      $stable(negFlag) && $stable(zeroFlag))
    else $error("load literal wrong");

  a_bank_nibble: assert property (@(posedge clock) disable iff (rst)
    freshDecode && instrWord[WORD_W-1:OPC8_LSB] == OPC_LOAD_BANK |->
      ##4 bankSelect == {{(DATA_W-BANK_W){1'b0}},
                         $past(instrWord[BANK_W-1:0], 4)})
    else $error("bank nibble wrong");

  a_store_acc: assert property (@(posedge clock) disable iff (rst)
    phase == PH_WRITE && state_reg.op == OP_STORE_ACC |->
      memWrite.en && memWrite.data == accumulator &&
      memWrite.addr == memRdAddr)
    else $error("store accumulator write wrong");

  a_dest_route: assert property (@(posedge clock) disable iff (rst)
    phase == PH_WRITE && (state_reg.op == OP_OR_FILE ||
      state_reg.op == OP_COPY_FILE) |-> memWrite.en == toFile)
    else $error("destination bit routing wrong");

  a_bank_addr: assert property (@(posedge clock) disable iff (rst)
    phase == PH_READ && fileOp && state_reg.instr[ACCESS_BIT] |->
      memRdAddr == {state_reg.bank[BANK_W-1:0], literal})
    else $error("banked address wrong");

  a_access_high: assert property (@(posedge clock) disable iff (rst)
    phase == PH_READ && fileOp && !state_reg.instr[ACCESS_BIT] &&
      literal > ACCESS_SPLIT |-> memRdAddr == {ACCESS_HIGH, literal})
    else $error("access bank address wrong");

  a_move_write: assert property (@(posedge clock) disable iff (rst)
    phase == PH_WRITE && state_reg.op == OP_F2F_DST && memWrite.en |->
      memWrite.addr == state_reg.instr[ADDR_W-1:0] &&
      memWrite.data == state_reg.opnd
      ##1 $stable(negFlag) && $stable(zeroFlag))
    else $error("file to file copy wrong");

  a_ptr_low: assert property (@(posedge clock) disable iff (rst)
    phase == PH_WRITE && state_reg.op == OP_PTR_LOW &&
      state_reg.ptrSel <= PTR_LAST |=>
      pointers[$past(state_reg.ptrSel)][DATA_W-1:0] == $past(literal))
    else $error("pointer low byte wrong");

endmodule : orm_exec

// File: design/orm_flag_calc.sv
// Negative and zero flag computation for an 8-bit result
`timescale 1ns/10ps
module orm_flag_calc
  import orm_pkg::*;
(
  input  wire logic [DATA_W-1:0] value,
  output      logic              negOut,
  output      logic              zeroOut
);

  // ------------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------------
  assign negOut  = value[DATA_W-1];
  assign zeroOut = (value == '0);

endmodule : orm_flag_calc

// File: verification/orm_data_mem.sv
// Behavioural data memory that stands beside the executer
`timescale 1ns/10ps
module orm_data_mem
  import orm_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [ADDR_W-1:0] rdAddr,
  input  wire orm_write_type     wrReq,
  output      logic [DATA_W-1:0] rdData
);
  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Varied fill so an unloaded byte reads as zero only where its low address byte is a5
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = i[7:0] ^ 8'ha5;
    end
  end

  // Read is asynchronous; the executer samples it at the end of its read
  assign rdData = mem[rdAddr];

  // Write lands at the edge that ends the write quarter
  always @(posedge clock) begin
    if (wrReq.en === 1'b1) begin
      mem[wrReq.addr] <= wrReq.data;
    end
  end
endmodule : orm_data_mem

// File: verification/tb_top.sv
// Self-checking testbench for the OR, literal and move executer
`timescale 1ns/10ps
module tb_top
  import orm_pkg::*;
;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic              clock;
  logic              rst;
  logic [WORD_W-1:0] instrWord;
  logic              extEnable;
  logic [DATA_W-1:0] memRdData;
  logic              fetchStrobe;
  logic [ADDR_W-1:0] memRdAddr;
  orm_write_type     memWrite;
  logic [DATA_W-1:0] accumulator;
  logic [DATA_W-1:0] bankSelect;
  orm_ptr_type       pointers;
  logic              negFlag;
  logic              zeroFlag;
  orm_phase_type     phase;
  int                nErrors;
  int                checkCount;

  orm_exec uut (
    .clock(clock), .rst(rst), .instrWord(instrWord),
    .extEnable(extEnable), .memRdData(memRdData),
    .fetchStrobe(fetchStrobe), .memRdAddr(memRdAddr),
    .memWrite(memWrite), .accumulator(accumulator),
    .bankSelect(bankSelect), .pointers(pointers), .negFlag(negFlag),
    .zeroFlag(zeroFlag), .phase(phase)
  );

  orm_data_mem memModel (
    .clock(clock), .rdAddr(memRdAddr), .wrReq(memWrite),
    .rdData(memRdData)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic testDone;
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : testDone

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for the decode quarter, sampled at the falling edge
  task automatic waitFetch;
    int n;
    n = 0;
    while (fetchStrobe !== 1'b1) begin
      n++;
      if (n > 8) begin
        nErrors++;
        testDone();
      end
      @(negedge clock);
    end
  endtask : waitFetch

  // Present a word in the decode quarter and let the taking edge pass
  task automatic issue(input logic [WORD_W-1:0] w);
    waitFetch();
    instrWord = w;
    @(negedge clock);
  endtask : issue

  // Whole instruction: results are visible at the next decode quarter
  task automatic run(input logic [WORD_W-1:0] w);
    issue(w);
    waitFetch();
  endtask : run

  task automatic flags(input logic n, input logic z);
    chk({15'h0, negFlag}, {15'h0, n});
    chk({15'h0, zeroFlag}, {15'h0, z});
  endtask : flags

  // ------------------------------------------------------------------
  // Tables
  // ------------------------------------------------------------------
  logic [15:0] stW [4]   = '{16'h6f20, 16'h6e70, 16'h6e10, 16'h6fff};
  logic [11:0] stA [4]   = '{12'h520, 12'hf70, 12'h010, 12'h5ff};
  logic [15:0] lpW1 [3]  = '{16'hee23, 16'hee0f, 16'hee15};
  logic [15:0] lpW2 [3]  = '{16'hf0ab, 16'hf0ff, 16'hf0a0};
  logic [1:0]  lpSel [3] = '{2'h2, 2'h0, 2'h1};
  logic [11:0] lpVal [3] = '{12'h3ab, 12'hfff, 12'h5a0};

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    nErrors = 0;
    checkCount = 0;
    rst = 1'b1;
    instrWord = 16'h0000;
    extEnable = 1'b0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    run(16'h0e9a);
    chk(accumulator, 16'h9a);
    flags(0, 0);
    run(16'h0935);
    chk(accumulator, 16'hbf);
    flags(1, 0);
    run(16'h0e00);
    chk(accumulator, 16'h00);
    flags(1, 0);
    run(16'h0900);
    flags(0, 1);
    run(16'h01f5);
    chk(bankSelect, 16'h05);
    flags(0, 1);
    run(16'h0e4f);
    issue(stW[0]);
    chk(phase, PH_READ);
    chk(memWrite.en, 0);
    @(negedge clock);
    chk(phase, PH_PROCESS);
    chk(memWrite.en, 0);
    @(negedge clock);
    chk(phase, PH_WRITE);
    chk(memWrite.en, 1);
    chk(memWrite.addr, stA[0]);
    chk(memWrite.data, 16'h4f);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        run(stW[i]);
      end else begin
        waitFetch();
      end
      chk(memModel.mem[stA[i]], 16'h4f);
      flags(0, 1);
    end
    memModel.mem[12'h513] = 8'h13;
    run(16'h0e91);
    issue(16'h1113);
    chk(memRdAddr, 16'h513);
    waitFetch();
    chk(accumulator, 16'h93);
    flags(1, 0);
    chk(memModel.mem[12'h513], 16'h13);
    run(16'h1313);
    chk(memModel.mem[12'h513], 16'h93);
    memModel.mem[12'h022] = 8'h22;
    memModel.mem[12'hff0] = 8'h80;
    memModel.mem[12'h5aa] = 8'h00;
    run(16'h5022);
    chk(accumulator, 16'h22);
    flags(0, 0);
    run(16'h52f0);
    chk(memModel.mem[12'hff0], 16'h80);
    chk(accumulator, 16'h22);
    flags(1, 0);
    run(16'h51aa);
    chk(accumulator, 16'h00);
    flags(0, 1);
    for (int i = 0; i < 3; i++) begin
      run(lpW1[i]);
      chk(pointers[lpSel[i]], {lpVal[i][11:8], 8'h00});
      run(lpW2[i]);
      chk(pointers[lpSel[i]], lpVal[i]);
    end
    // A selector of three names no pointer, so all three stay put
    run(16'hee37);
    run(16'hf012);
    chk(pointers[0], 16'hfff);
    chk(pointers[1], 16'h5a0);
    chk(pointers[2], 16'h3ab);
    // Indexed addressing only applies below the split with access bit 0
    extEnable = 1'b1;
    run(16'h0e5c);
    run(16'h6e10);
    chk(memModel.mem[12'h3bb], 16'h5c);
    run(16'h6e60);
    chk(memModel.mem[12'hf60], 16'h5c);
    extEnable = 1'b0;
    // Destinations stay clear of program counter and stack bytes
    memModel.mem[12'h123] = 8'h33;
    run(16'hc123);
    run(16'hffff);
    chk(memModel.mem[12'hfff], 16'h33);
    flags(0, 1);
    run(16'hcfe0);
    run(16'hf000);
    chk(memModel.mem[12'h000], 16'h5c);
    run(16'hc123);
    run(16'hffe0);
    chk(accumulator, 16'h33);
    flags(0, 1);
    testDone();
  end
endmodule : tb_top
